// file: design/gtw_core.sv
// Operation
// - Port input not latched; sampled at read
// - Output latch holds until rewritten
// - Direction one tristates pin, zero drives
// - Direction write-only, loaded by op, resets ones
// - Port read returns pin levels
// - Bit ops read pins, rewrite whole latch
// - Event counter sixteen bits, source selectable
// - Sources: pin rise, fall, slow, iclk/4
// - Event counter independent of core sleep
// - Disable bit stops event counter
// - Overflow sets flag, interrupts, wakes core
// - Tick timer fifteen bits, prescale on load
// - Unmasked tick overflow sets flag, interrupts
// - Two unkicked tick overflows reset core
// - Kick op, firing, master or power reset clear watchdog state
// - All interrupts vector 0x0200, equal priority
// - Inputs: pin seven, SMBus, peripheral latch
// - Event latch sets regardless of enable
// - Status reads never alter flags
// - Writing one clears status bit
// - Pins 0-2 SPI, pin3 stays port I/O
// - Enables clear on master or power reset
`timescale 1ns/1ps
`include "gtw_params.svh"

module gtw_core (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    // External pins
    input  wire logic [7:0]  gp_pin_in_i,
    output logic      [7:0]  gp_pin_out_o,
    output logic      [7:0]  gp_pin_oe_o,
    input  wire logic        external_master_reset_n_i,
    input  wire logic        osc32k_i,
    input  wire logic        instr_osc_i,
    // SPI engine sharing pins 0 to 2
    input  wire logic        spi_mode_i,
    input  wire logic [2:0]  spi_out_i,
    input  wire logic [2:0]  spi_oe_i,
    // Core port operations
    input  wire logic        port_rd_i,
    output logic      [7:0]  port_rd_data_o,
    input  wire logic        port_wr_i,
    input  wire logic [7:0]  port_wr_data_i,
    input  wire logic        bit_op_i,
    input  wire logic        bit_set_i,
    input  wire logic [2:0]  bit_idx_i,
    input  wire logic        direction_load_i,
    input  wire logic [7:0]  w_reg_i,
    // Core timer operations
    input  wire logic        option_load_i,
    input  wire logic [7:0]  option_data_i,
    input  wire logic        event_flag_clr_i,
    input  wire logic        tick_flag_clr_i,
    input  wire logic        tick_irq_clear_op_i,
    input  wire logic        hang_timer_kick_op_i,
    output logic             event_overflow_flag_o,
    output logic             tick_overflow_flag_o,
    output logic             timer_irq_o,
    output logic             hang_reset_o,
    // Peripheral access port
    input  wire logic [7:0]  periph_events_i,
    input  wire logic [7:0]  pa_addr_i,
    input  wire logic        pa_rd_i,
    input  wire logic        pa_wr_i,
    input  wire logic [7:0]  pa_wdata_i,
    output logic      [7:0]  pa_rdata_o,
    // Interrupts to the core
    input  wire logic        smbus_irq_i,
    output logic      [2:0]  irq_lines_o,
    output logic      [15:0] irq_vector_o,
    output logic             wake_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [7:0] bit_mod(input logic [7:0] v, input logic [2:0] idx,
                                           input logic set);
        logic [7:0] r;
        r      = v;
        r[idx] = set;
        return r;
    endfunction

    function automatic logic pa_hit(input logic [7:0] a, input logic [7:0] reg_addr);
        return a == reg_addr;
    endfunction

    function automatic logic [14:0] tick_limit(input logic [2:0] ps);
        logic [2:0] sh;
        sh = (ps > `GTW_TICK_MAX_SHIFT) ? `GTW_TICK_MAX_SHIFT : ps;
        return `GTW_TICK_FULL >> sh;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    gtw_sync_if #(.W(`GTW_SYNC_W)) sync ();

    gtw_pin_sync #(.W(`GTW_SYNC_W)) u_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .raw_i   ({~external_master_reset_n_i, instr_osc_i, osc32k_i, gp_pin_in_i}),
        .sync    (sync)
    );

    logic [7:0] pin_lvl;
    logic       por_rst;
    logic       core_rst;
    logic       wd_fire_q;

    assign pin_lvl  = sync.level[7:0];
    assign por_rst  = reset_i | sync.level[`GTW_LANE_EXTERNAL_MASTER_RESET];
    assign core_rst = por_rst | wd_fire_q;

    ////////////////////////////////////////////////////////////////////////////////
    // General-purpose port

    logic [7:0] data_q;
    logic [7:0] data_d;
    logic [7:0] dir_q;
    logic [7:0] dir_d;
    logic [7:0] rd_q;
    logic [7:0] rd_d;

    always_comb
    begin
        data_d = data_q;
        dir_d  = dir_q;
        rd_d   = rd_q;
        if (port_rd_i)
            rd_d = pin_lvl;
        if (port_wr_i)
            data_d = port_wr_data_i;
        if (bit_op_i)
            data_d = bit_mod(pin_lvl, bit_idx_i, bit_set_i);
        if (direction_load_i)
            dir_d = w_reg_i;
        if (core_rst)
        begin
            data_d = `GTW_DATA_RESET;
            dir_d  = `GTW_DIR_RESET;
        end
    end

    always_ff @(posedge clock_i)
    begin
        data_q <= data_d;
        dir_q  <= dir_d;
        rd_q   <= rd_d;
        if (reset_i)
            rd_q <= '0;
    end

    // Pins 0 to 2 belong to the SPI engine while it is active
    always_comb
    begin
        gp_pin_out_o = data_q;
        gp_pin_oe_o  = ~dir_q;
        if (spi_mode_i)
        begin
            gp_pin_out_o[`GTW_SPI_PINS-1:0] = spi_out_i;
            gp_pin_oe_o[`GTW_SPI_PINS-1:0]  = spi_oe_i;
        end
    end

    assign port_rd_data_o = rd_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Option register, event counter and tick timer

    logic [7:0]  opt_q;
    logic [7:0]  opt_d;
    logic [15:0] ecnt_q;
    logic [15:0] ecnt_d;
    logic [1:0]  div_q;
    logic [1:0]  div_d;
    logic [14:0] tcnt_q;
    logic [14:0] tcnt_d;
    logic        evt_tick;
    logic        evt_ovf;
    logic        tick_wrap;
    logic        tick_full;
    logic        osc_rise;
    gtw_pkg::gtw_src_type src;

    assign src      = gtw_pkg::gtw_src_type'(opt_q[`GTW_OPT_SRC_HI:`GTW_OPT_SRC_LO]);
    assign osc_rise = sync.rise[`GTW_LANE_OSC];

    always_comb
    begin
        opt_d  = option_load_i ? option_data_i : opt_q;
        div_d  = div_q;
        if (sync.rise[`GTW_LANE_ICLK])
            div_d = div_q + 2'h1;
        unique case (src)
            gtw_pkg::SRC_PIN_RISE:  evt_tick = sync.rise[`GTW_EVT_PIN];
            gtw_pkg::SRC_PIN_FALL:  evt_tick = sync.fall[`GTW_EVT_PIN];
            gtw_pkg::SRC_SLOW_OSC:  evt_tick = osc_rise;
            gtw_pkg::SRC_ICLK_DIV4: evt_tick = sync.rise[`GTW_LANE_ICLK]
                                               && (div_q == `GTW_ICLK_LAST);
        endcase
        // Counting does not depend on any core sleep state
        evt_tick = evt_tick && !opt_q[`GTW_OPT_DIS];
        ecnt_d   = evt_tick ? ecnt_q + 16'h0001 : ecnt_q;
        evt_ovf  = evt_tick && (ecnt_q == `GTW_EVT_FULL);
        tcnt_d   = osc_rise ? tcnt_q + 15'h0001 : tcnt_q;
        tick_wrap = osc_rise
                    && ((tcnt_q & tick_limit(opt_q[`GTW_OPT_PS_HI:`GTW_OPT_PS_LO]))
                        == tick_limit(opt_q[`GTW_OPT_PS_HI:`GTW_OPT_PS_LO]));
        tick_full = osc_rise && (tcnt_q == `GTW_TICK_FULL);
    end

    always_ff @(posedge clock_i)
    begin
        if (por_rst)
        begin
            opt_q  <= `GTW_OPT_RESET;
            ecnt_q <= '0;
            div_q  <= '0;
            tcnt_q <= '0;
        end
        else
        begin
            opt_q  <= opt_d;
            ecnt_q <= ecnt_d;
            div_q  <= div_d;
            tcnt_q <= tcnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer flags and watchdog

    logic evt_flag_q;
    logic evt_flag_d;
    logic tick_flag_q;
    logic tick_flag_d;
    logic tick_irq_q;
    logic tick_irq_d;
    logic tick_set;
    logic wd_fire_d;
    gtw_pkg::gtw_wd_type wd_state_q;
    gtw_pkg::gtw_wd_type wd_state_d;

    always_comb
    begin
        tick_set    = tick_wrap && !opt_q[`GTW_OPT_TICK_IRQ_MASK];
        evt_flag_d  = (evt_flag_q && !event_flag_clr_i) || evt_ovf;
        tick_flag_d = (tick_flag_q && !tick_flag_clr_i) || tick_set;
        tick_irq_d  = (tick_irq_q && !tick_irq_clear_op_i) || tick_set;
        wd_state_d  = wd_state_q;
        wd_fire_d   = 1'b0;
        unique case (wd_state_q)
            gtw_pkg::WD_IDLE:
                if (tick_full)
                    wd_state_d = gtw_pkg::WD_ARMED;
            gtw_pkg::WD_ARMED:
                if (tick_full)
                begin
                    wd_fire_d  = 1'b1;
                    wd_state_d = gtw_pkg::WD_IDLE;
                end
                else if (hang_timer_kick_op_i)
                    wd_state_d = gtw_pkg::WD_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (core_rst)
        begin
            evt_flag_q  <= 1'b0;
            tick_flag_q <= 1'b0;
            tick_irq_q  <= 1'b0;
        end
        else
        begin
            evt_flag_q  <= evt_flag_d;
            tick_flag_q <= tick_flag_d;
            tick_irq_q  <= tick_irq_d;
        end
        if (por_rst)
        begin
            wd_state_q <= gtw_pkg::WD_IDLE;
            wd_fire_q  <= 1'b0;
        end
        else
        begin
            wd_state_q <= wd_state_d;
            wd_fire_q  <= wd_fire_d;
        end
    end

    assign event_overflow_flag_o = evt_flag_q;
    assign tick_overflow_flag_o  = tick_flag_q;
    assign timer_irq_o           = evt_flag_q | tick_irq_q;
    assign hang_reset_o          = wd_fire_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Peripheral event latch and interrupt routing

    logic [7:0] st_q;
    logic [7:0] st_d;
    logic [7:0] en_q;
    logic [7:0] en_d;
    logic [7:0] pard_q;
    logic [7:0] pard_d;
    logic       wr_st;

    always_comb
    begin
        wr_st  = pa_wr_i && pa_hit(pa_addr_i, `GTW_PA_STAT_ADDR);
        // A new event wins over a clear in the same cycle
        st_d   = (st_q & ~(wr_st ? pa_wdata_i : 8'h00))
                 | periph_events_i;
        en_d   = (pa_wr_i && pa_hit(pa_addr_i, `GTW_PA_EN_ADDR)) ? pa_wdata_i : en_q;
        pard_d = pard_q;
        if (pa_rd_i)
        begin
            if (pa_hit(pa_addr_i, `GTW_PA_STAT_ADDR))
                pard_d = st_q;
            else if (pa_hit(pa_addr_i, `GTW_PA_EN_ADDR))
                pard_d = en_q;
            else
                pard_d = 8'h00;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (por_rst)
        begin
            st_q   <= `GTW_STAT_RESET;
            en_q   <= `GTW_EN_RESET;
            pard_q <= '0;
        end
        else
        begin
            st_q   <= st_d;
            en_q   <= en_d;
            pard_q <= pard_d;
        end
    end

    assign pa_rdata_o      = pard_q;
    assign irq_lines_o     = {|(st_q & en_q), smbus_irq_i,
                              pin_lvl[`GTW_PIN_IRQ_INPUT_PIN]};
    assign irq_vector_o    = `GTW_IRQ_VECTOR;
    assign wake_o          = timer_irq_o | (|irq_lines_o);

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    chk_dir_reset: assert property (core_rst |=> dir_q == `GTW_DIR_RESET)
        else $error("direction latch not all ones after reset");
    chk_pin_drive: assert property (gp_pin_oe_o[7:3] == ~dir_q[7:3])
        else $error("output enable does not follow direction");
    chk_port_read: assert property (port_rd_i |=> port_rd_data_o == $past(pin_lvl))
        else $error("port read not equal to pin levels");
    chk_latch_hold: assert property (!port_wr_i && !bit_op_i && !core_rst
                                     |=> $stable(data_q))
        else $error("output latch changed without a write");
    chk_bit_op: assert property (bit_op_i && !core_rst
        |=> data_q[$past(bit_idx_i)] == $past(bit_set_i))
        else $error("bit operation result wrong");
    chk_evt_stop: assert property (opt_q[`GTW_OPT_DIS] && !por_rst
                                   |=> $stable(ecnt_q))
        else $error("event counter moved while disabled");
    chk_evt_flag: assert property (evt_ovf && !core_rst
                                   |=> evt_flag_q && timer_irq_o)
        else $error("event overflow did not raise flag");
    chk_tick_flag: assert property (tick_set && !core_rst
                                    |=> tick_flag_q && tick_irq_q)
        else $error("tick overflow did not raise flag");
    chk_wd_fire: assert property (wd_fire_q |-> $past(wd_state_q) == gtw_pkg::WD_ARMED)
        else $error("watchdog fired without being armed");
    chk_stat_read: assert property (pa_rd_i && !pa_wr_i && !por_rst
        |=> st_q == ($past(st_q) | $past(periph_events_i)))
        else $error("status read changed flags");
    chk_stat_set: assert property (periph_events_i != 8'h00 && !por_rst
        |=> (st_q & $past(periph_events_i)) == $past(periph_events_i))
        else $error("event not latched");
    chk_stat_clear: assert property (wr_st && !por_rst
        |=> (st_q & $past(pa_wdata_i & ~periph_events_i)) == 8'h00)
        else $error("write one did not clear status");

    cov_evt_ovf:  cover property (evt_ovf);
    cov_wd_fire:  cover property (wd_fire_q);
    cov_periph_irq_input:     cover property (irq_lines_o[2]);
    cov_bit_op:   cover property (bit_op_i ##1 port_rd_i);

endmodule

// file: design/gtw_params.svh
`ifndef GTW_PARAMS_SVH
`define GTW_PARAMS_SVH

// Option register fields
`define GTW_OPT_SRC_LO      0
`define GTW_OPT_SRC_HI      1
`define GTW_OPT_DIS         2
`define GTW_OPT_PS_LO       3
`define GTW_OPT_PS_HI       5
`define GTW_OPT_TICK_IRQ_MASK        6
`define GTW_OPT_RESET       8'h44

// Port latches
`define GTW_DATA_RESET      8'hff
`define GTW_DIR_RESET       8'hff
`define GTW_SPI_PINS        3
`define GTW_EVT_PIN         4
`define GTW_PIN_IRQ_INPUT_PIN        7

// Synchroniser lanes beyond the eight port pins
`define GTW_SYNC_W          11
`define GTW_LANE_OSC        8
`define GTW_LANE_ICLK       9
`define GTW_LANE_EXTERNAL_MASTER_RESET       10

// Peripheral event latch
`define GTW_PA_STAT_ADDR    8'h0e
`define GTW_PA_EN_ADDR      8'h0f
`define GTW_STAT_RESET      8'h00
`define GTW_EN_RESET        8'h00

// Timers
`define GTW_EVT_FULL        16'hffff
`define GTW_TICK_FULL       15'h7fff
`define GTW_TICK_MAX_SHIFT  3'h6
`define GTW_ICLK_LAST       2'h3

// Interrupt vector
`define GTW_IRQ_VECTOR      16'h0200

`endif

// file: design/gtw_pin_sync.sv
`timescale 1ns/1ps

module gtw_pin_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         reset_i,
    // Raw asynchronous inputs
    input  wire logic [W-1:0] raw_i,
    // Filtered levels and edges
    gtw_sync_if.src           sync
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] level_d;
    logic [W-1:0] rise_q;
    logic [W-1:0] rise_d;
    logic [W-1:0] fall_q;
    logic [W-1:0] fall_d;

    // A change is accepted only when the second and third stages agree
    always_comb
    begin
        level_d = ((s2_q ^ s3_q) & level_q) | (~(s2_q ^ s3_q) & s3_q);
        rise_d  = level_d & ~level_q;
        fall_d  = ~level_d & level_q;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_q <= '0;
            rise_q  <= '0;
            fall_q  <= '0;
        end
        else
        begin
            s1_q    <= raw_i;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
            rise_q  <= rise_d;
            fall_q  <= fall_d;
        end
    end

    assign sync.level = level_q;
    assign sync.rise  = rise_q;
    assign sync.fall  = fall_q;

endmodule

// file: design/gtw_pkg.sv
package gtw_pkg;

    typedef enum logic [1:0] {
        SRC_PIN_RISE  = 2'b00,
        SRC_PIN_FALL  = 2'b01,
        SRC_SLOW_OSC  = 2'b10,
        SRC_ICLK_DIV4 = 2'b11
    } gtw_src_type;

    typedef enum logic {
        WD_IDLE  = 1'b0,
        WD_ARMED = 1'b1
    } gtw_wd_type;

endpackage

// file: design/gtw_sync_if.sv
`timescale 1ns/1ps

interface gtw_sync_if #(parameter int W = 8);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// file: dv/gtw_core_tb.sv
`timescale 1ns/1ps

module gtw_core_tb;
    logic        clock_i, reset_i, mrst_n, osc, osc_run, spi_mode, port_rd, port_wr;
    logic        bit_op, bit_set, dir_ld, opt_ld, evt_clr, tick_clr, tick_op, kick;
    logic        pa_rd, pa_wr, smbus, evt_flag, tick_flag, timer_irq, hang, wake;
    logic [2:0]  spi_out, spi_oe, bit_idx, irq_lines;
    logic [7:0]  pins, pin_out, pin_oe, rd_data, wr_data, w_reg, opt_data, ext_val, ext_en;
    logic [7:0]  events, pa_addr, pa_wdata, pa_rdata;
    logic [15:0] irq_vector;
    int          mismatches;
    int          checked;

    gtw_core gtw_core_i (.clock_i(clock_i), .reset_i(reset_i), .gp_pin_in_i(pins),
        .gp_pin_out_o(pin_out), .gp_pin_oe_o(pin_oe), .external_master_reset_n_i(mrst_n),
        .osc32k_i(osc), .instr_osc_i(1'b0), .spi_mode_i(spi_mode), .spi_out_i(spi_out),
        .spi_oe_i(spi_oe), .port_rd_i(port_rd), .port_rd_data_o(rd_data),
        .port_wr_i(port_wr), .port_wr_data_i(wr_data), .bit_op_i(bit_op),
        .bit_set_i(bit_set), .bit_idx_i(bit_idx), .direction_load_i(dir_ld),
        .w_reg_i(w_reg), .option_load_i(opt_ld), .option_data_i(opt_data),
        .event_flag_clr_i(evt_clr), .tick_flag_clr_i(tick_clr),
        .tick_irq_clear_op_i(tick_op), .hang_timer_kick_op_i(kick),
        .event_overflow_flag_o(evt_flag), .tick_overflow_flag_o(tick_flag),
        .timer_irq_o(timer_irq), .hang_reset_o(hang), .periph_events_i(events),
        .pa_addr_i(pa_addr), .pa_rd_i(pa_rd), .pa_wr_i(pa_wr), .pa_wdata_i(pa_wdata),
        .pa_rdata_o(pa_rdata), .smbus_irq_i(smbus), .irq_lines_o(irq_lines),
        .irq_vector_o(irq_vector), .wake_o(wake));

    gtw_pin_model gtw_pin_model_i (.drive_val_i(pin_out), .drive_en_i(pin_oe),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_level_o(pins));

    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // Slow oscillator, sixteen core clocks per period while running
    initial
    begin
        osc = 1'b0;
        forever
        begin
            repeat (8) @(posedge clock_i);
            #1 if (osc_run) osc = ~osc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic step;
        @(posedge clock_i);
        #1;
    endtask

    task automatic settle;
        repeat (8) step;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked = checked + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic port_write(input logic [7:0] d);
        step;
        wr_data = d;
        port_wr = 1'b1;
        step;
        port_wr = 1'b0;
    endtask

    task automatic dir_load(input logic [7:0] d);
        step;
        w_reg = d;
        dir_ld = 1'b1;
        step;
        dir_ld = 1'b0;
    endtask

    task automatic port_read(input logic [4:0] exp);
        step;
        port_rd = 1'b1;
        step;
        port_rd = 1'b0;
        check("port read", {11'h0, exp}, {11'h0, rd_data[7:3]});
    endtask

    task automatic bit_write(input logic set, input logic [2:0] idx);
        step;
        bit_set = set;
        bit_idx = idx;
        bit_op = 1'b1;
        step;
        bit_op = 1'b0;
    endtask

    task automatic pa_write(input logic [7:0] a, input logic [7:0] d);
        step;
        pa_addr = a;
        pa_wdata = d;
        pa_wr = 1'b1;
        step;
        pa_wr = 1'b0;
    endtask

    task automatic pa_read(input logic [7:0] a, input logic [7:0] exp);
        step;
        pa_addr = a;
        pa_rd = 1'b1;
        step;
        pa_rd = 1'b0;
        check("periph read", {8'h0, exp}, {8'h0, pa_rdata});
    endtask

    task automatic load_option(input logic [7:0] d);
        step;
        opt_data = d;
        opt_ld = 1'b1;
        step;
        opt_ld = 1'b0;
    endtask

    task automatic print_verdict;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(25ns * 60000);
        mismatches = mismatches + 1;
        $display("watchdog expired");
        print_verdict;
    end

    initial
    begin
        {reset_i, mrst_n, osc_run, spi_mode, port_rd, port_wr, bit_op, bit_set} = 8'hc0;
        {dir_ld, opt_ld, evt_clr, tick_clr, tick_op, kick, pa_rd, pa_wr, smbus} = 9'h0;
        {spi_out, spi_oe, bit_idx} = 9'h0;
        {wr_data, w_reg, opt_data, ext_val, ext_en, events, pa_addr, pa_wdata} = 64'h0;
        mismatches = 0;
        checked = 0;
        repeat (16) @(posedge clock_i);
        #1 reset_i = 1'b0;
        settle;
        check("oe after reset", 16'h0000, {11'h0, pin_oe[7:3]});
        check("out after reset", 16'h001f, {11'h0, pin_out[7:3]});
        check("vector", 16'h0200, irq_vector);
        $display("test reset done");

        port_write(8'ha5);
        dir_load(8'h00);
        check("out latch", 16'h0014, {11'h0, pin_out[7:3]});
        check("oe driven", 16'h001f, {11'h0, pin_oe[7:3]});
        settle;
        port_read(5'h14);
        ext_en = 8'h20;
        settle;
        port_read(5'h10);
        check("latch kept", 16'h0014, {11'h0, pin_out[7:3]});
        dir_load(8'hff);
        check("oe released", 16'h0000, {11'h0, pin_oe[7:3]});
        ext_en = 8'h00;
        settle;
        port_read(5'h1f);
        $display("test port done");

        // Output latch is written whole before direction changes
        port_write(8'h00);
        dir_load(8'h0f);
        settle;
        bit_write(1'b1, 3'h7);
        check("bit set", 16'h0011, {11'h0, pin_out[7:3]});
        settle;
        bit_write(1'b0, 3'h7);
        check("bit clear", 16'h0001, {11'h0, pin_out[7:3]});
        $display("test bit ops done");

        spi_mode = 1'b1;
        spi_out = 3'h5;
        spi_oe = 3'h3;
        step;
        check("spi pins", 16'h0053, {8'h0, 1'b0, pin_out[2:0], 1'b0, pin_oe[2:0]});
        spi_mode = 1'b0;
        ext_en = 8'h80;
        ext_val = 8'h80;
        smbus = 1'b1;
        settle;
        check("irq lines", 16'h0003, {13'h0, irq_lines});
        check("wake", 16'h0001, {15'h0, wake});
        {ext_en, ext_val, smbus} = 17'h0;
        $display("test irq lines done");

        step;
        events = 8'h81;
        step;
        events = 8'h00;
        pa_read(8'h0e, 8'h81);
        pa_read(8'h0e, 8'h81);
        check("masked line", 16'h0000, {15'h0, irq_lines[2]});
        pa_write(8'h0f, 8'h01);
        step;
        check("enabled line", 16'h0001, {15'h0, irq_lines[2]});
        pa_read(8'h0f, 8'h01);
        pa_write(8'h0e, 8'h00);
        pa_read(8'h0e, 8'h81);
        pa_write(8'h0e, 8'h01);
        pa_read(8'h0e, 8'h80);
        check("cleared line", 16'h0000, {15'h0, irq_lines[2]});
        pa_read(8'h10, 8'h00);
        $display("test peripheral latch done");

        load_option(8'h74);
        osc_run = 1'b1;
        repeat (600 * 16) step;
        check("masked tick", 16'h0000, {15'h0, tick_flag});
        load_option(8'h34);
        for (int n = 0; n < 12000 && tick_flag !== 1'b1; n++)
            step;
        osc_run = 1'b0;
        check("tick flag", 16'h0001, {15'h0, tick_flag});
        check("timer irq", 16'h0001, {15'h0, timer_irq});
        check("tick wake", 16'h0001, {15'h0, wake});
        step;
        tick_op = 1'b1;
        step;
        tick_op = 1'b0;
        tick_clr = 1'b1;
        step;
        tick_clr = 1'b0;
        step;
        check("tick cleared", 16'h0000, {14'h0, tick_flag, timer_irq});
        check("no hang", 16'h0000, {15'h0, hang});
        $display("test tick timer done");

        mrst_n = 1'b0;
        settle;
        mrst_n = 1'b1;
        settle;
        pa_read(8'h0f, 8'h00);
        check("oe after master", 16'h0000, {11'h0, pin_oe[7:3]});
        $display("test master reset done");
        print_verdict;
    end
endmodule

// file: dv/gtw_pin_model.sv
`timescale 1ns/1ps

module gtw_pin_model (
    // Device side
    input  wire logic [7:0] drive_val_i,
    input  wire logic [7:0] drive_en_i,
    // External circuitry
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_en_i,
    // Resolved pin levels
    output logic      [7:0] pin_level_o
);
    // A strong external source wins over the device driver, an undriven pin is pulled up
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (ext_en_i[i])
                pin_level_o[i] = ext_val_i[i];
            else if (drive_en_i[i])
                pin_level_o[i] = drive_val_i[i];
            else
                pin_level_o[i] = 1'b1;
        end
    end
endmodule
